/* rtl/dtb_trace.sv */
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
// Function
// - Inside mode matches when lower bound <= address <= upper bound.
// - Outside mode matches when address below lower or above upper bound.
// - Tagged match acts just before the tagged instruction executes.
// - Forced match acts at first instruction boundary after comparator match.
// - Breakpoint either enters background debug or requests a software interrupt.
// - Software trigger bit forces final state without comparator match.
// - Trace lines are 20 bits, read through a 16-bit window.
// - Every second valid window read (the upper half) advances the read pointer.
// - Trace buffer is locked against reading while armed.
// - Only an aligned word write while disarmed unlocks reading.
// - Byte or misaligned window reads return zero, pointer unchanged.
// - Reads while armed or source select clear return zero, pointer kept.
// - Buffer contents undefined at power-on, kept over other resets.
// - Count register is always readable and ignores writes.
// - Full flag sets after 64 lines since arming; all lines then valid.
// - Full flag clears on arm write and power-on; mirrored in status bit 7.
// - Six-bit binary count holds valid lines, zero to 63.
// - Count wrap sets full flag; end-trigger mode keeps counting.
// - Count clears on arm write and power-on, kept over other resets.
// - Window reads never decrement the count.
// - Entering final state starts tracing and optional breakpoint.
// - Tracing is disabled while the system is secured.
module dtb_trace
  import dtb_pkg::*;
#(
  parameter int DEPTH_P = DEPTH
)
(
  // Clock and resets
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         sys_resetn,
  // Avalon-MM slave
  input  wire logic [5:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [3:0]   avs_byteenable,
  input  wire logic [31:0]  avs_writedata,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  // Monitored core
  input  wire dtb_cpu_bus_t cpu_bus,
  input  wire logic         secured,
  output dtb_brk_t          brk
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  localparam int PTR_W = $clog2(DEPTH_P);

  logic [LINE_W-1:0] mem [DEPTH_P];
  logic [15:0]       ctrl_r;
  logic [ADDR_W-1:0] lo_r, hi_r, data_a_r, dmask_a_r;
  logic [CNT_W-1:0]  count_r;
  logic              full_r;
  logic              lock_r;
  logic [PTR_W-1:0]  wr_ptr_r;
  logic [PTR_W-1:0]  rd_ptr_r;
  logic              rd_half_r;
  logic              pend_force_r;
  logic              pend_tag_r;
  dtb_seq_t          seq_r;
  logic              ack_r;
  logic [31:0]       rdata_nxt;

  logic       req;
  logic [3:0] reg_sel;
  logic       word_ok;
  logic       arm_wr;
  logic       win_rd_ok;
  logic       cmp_hit;
  logic       software_trigger_bit_evt;
  logic       enter_final;
  logic       trace_en;
  dtb_cmp_mode_t mode;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign reg_sel         = avs_address[5:2];
  assign word_ok         = (avs_address[1:0] == 2'b00) && (avs_byteenable[1:0] == 2'b11);
  assign arm_wr          = ack_r && avs_write && reg_sel == OFS_CTRL
                           && avs_byteenable[0] && avs_writedata[CTRL_ARM_BIT];
  assign mode            = dtb_cmp_mode_t'(ctrl_r[CTRL_MODE_LSB +: 2]);

  // One wait state: answer on second cycle of each request
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      ack_r <= 1'b0;
    else
      ack_r <= req & ~ack_r;
  end

  // ------------------------------------------------------------
  // Comparators
  // ------------------------------------------------------------
  function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  always_comb
  begin
    cmp_hit = 1'b0;
    if (cpu_bus.valid
        && (!ctrl_r[CTRL_RWEN_BIT] || cpu_bus.write == ctrl_r[CTRL_RW_BIT]))
    begin
      unique case (mode)
        CMP_SIMPLE:
          cmp_hit = (cpu_bus.addr == lo_r)
                    && (((cpu_bus.data ^ data_a_r) & dmask_a_r) == 16'h0000);
        CMP_INSIDE:
          cmp_hit = in_range(cpu_bus.addr, lo_r, hi_r);
        CMP_OUTSIDE:
          cmp_hit = !in_range(cpu_bus.addr, lo_r, hi_r);
        default:
          cmp_hit = 1'b0;
      endcase
    end
  end

  // Tagged hits wait for execution, forced hits for a boundary
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pend_tag_r   <= 1'b0;
      pend_force_r <= 1'b0;
    end
    else if (seq_r != SEQ_ARMED)
    begin
      pend_tag_r   <= 1'b0;
      pend_force_r <= 1'b0;
    end
    else
    begin
      pend_tag_r   <= (pend_tag_r & ~cpu_bus.tag_exec)
                      | (cmp_hit & cpu_bus.fetch & ctrl_r[CTRL_TAG_BIT]);
      pend_force_r <= (pend_force_r & ~cpu_bus.boundary)
                      | (cmp_hit & ~ctrl_r[CTRL_TAG_BIT]);
    end
  end

  assign software_trigger_bit_evt = (pend_tag_r & cpu_bus.tag_exec)
                    | (pend_force_r & cpu_bus.boundary)
                    | ctrl_r[CTRL_SOFTWARE_TRIGGER_BIT_BIT];

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  assign enter_final = (seq_r == SEQ_ARMED) && software_trigger_bit_evt;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      seq_r <= SEQ_IDLE;
    else if (arm_wr)
      seq_r <= SEQ_ARMED;
    else
    begin
      unique case (seq_r)
        SEQ_IDLE:  seq_r <= SEQ_IDLE;
        SEQ_ARMED: if (enter_final) seq_r <= SEQ_FINAL;
        SEQ_FINAL: if (!ctrl_r[CTRL_ENDTRIG_BIT]) seq_r <= SEQ_IDLE;
        default:   seq_r <= SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      brk <= '0;
    else
    begin
      brk.bgnd <= enter_final & ctrl_r[CTRL_BRK_EN_BIT] & ~ctrl_r[CTRL_BRK_SWI_BIT];
      brk.software_interrupt  <= enter_final & ctrl_r[CTRL_BRK_EN_BIT] & ctrl_r[CTRL_BRK_SWI_BIT];
    end
  end

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_r    <= CTRL_RESET;
      lo_r      <= '0;
      hi_r      <= '0;
      data_a_r  <= '0;
      dmask_a_r <= '0;
    end
    else
    begin
      if (enter_final)
        ctrl_r[CTRL_SOFTWARE_TRIGGER_BIT_BIT] <= 1'b0;
      if (ack_r && avs_write)
      begin
        unique case (reg_sel)
          OFS_CTRL:    ctrl_r    <= avs_writedata[15:0];
          OFS_CMP_A:   lo_r      <= avs_writedata[15:0];
          OFS_CMP_B:   hi_r      <= avs_writedata[15:0];
          OFS_DATA_A:  data_a_r  <= avs_writedata[15:0];
          OFS_DMASK_A: dmask_a_r <= avs_writedata[15:0];
          default:     ;
        endcase
        if (reg_sel == OFS_CTRL && arm_wr)
          ctrl_r[CTRL_SOFTWARE_TRIGGER_BIT_BIT] <= avs_writedata[CTRL_SOFTWARE_TRIGGER_BIT_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // Trace capture: power-on reset only
  // ------------------------------------------------------------
  assign trace_en = (seq_r == SEQ_FINAL) && cpu_bus.valid && !secured;

  always_ff @(posedge sys_clk)
  begin
    if (trace_en)
      mem[wr_ptr_r] <= {cpu_bus.write, 3'h0, cpu_bus.addr};
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count_r  <= '0;
      full_r   <= 1'b0;
      wr_ptr_r <= '0;
    end
    else if (arm_wr)
    begin
      count_r  <= '0;
      full_r   <= 1'b0;
      wr_ptr_r <= '0;
    end
    else if (trace_en)
    begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
      count_r  <= count_r + 1'b1;
      if (count_r == '1)
        full_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Window readout
  // ------------------------------------------------------------
  assign win_rd_ok = ack_r && avs_read && reg_sel == OFS_WINDOW && word_ok
                     && !lock_r && seq_r == SEQ_IDLE && ctrl_r[CTRL_TSRC_BIT];

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      lock_r <= 1'b1;
    else if (arm_wr || seq_r != SEQ_IDLE)
      lock_r <= 1'b1;
    else if (ack_r && avs_write && reg_sel == OFS_WINDOW && word_ok)
      lock_r <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_ptr_r  <= '0;
      rd_half_r <= 1'b0;
    end
    else if (arm_wr)
    begin
      rd_ptr_r  <= '0;
      rd_half_r <= 1'b0;
    end
    else if (win_rd_ok)
    begin
      rd_half_r <= ~rd_half_r;
      if (rd_half_r)
        rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    unique case (reg_sel)
      OFS_WINDOW:
        if (win_rd_ok)
          rdata_nxt = rd_half_r ? {28'h0, mem[rd_ptr_r][19:16]}
                                : {16'h0, mem[rd_ptr_r][15:0]};
      OFS_COUNT:   rdata_nxt = {24'h0, full_r, 1'b0, count_r};
      OFS_CTRL:    rdata_nxt = {16'h0, ctrl_r};
      OFS_STATUS:  rdata_nxt = {24'h0, full_r, 5'h0, lock_r, seq_r != SEQ_IDLE};
      OFS_CMP_A:   rdata_nxt = {16'h0, lo_r};
      OFS_CMP_B:   rdata_nxt = {16'h0, hi_r};
      OFS_DATA_A:  rdata_nxt = {16'h0, data_a_r};
      OFS_DMASK_A: rdata_nxt = {16'h0, dmask_a_r};
      default:     rdata_nxt = 32'h0000_0000;
    endcase
  end

  assign avs_readdata = rdata_nxt;

endmodule : dtb_trace

/* rtl/dtb_pkg.sv */
package dtb_pkg;

  // ------------------------------------------------------------
  // Register map (word indices; byte address is index times four)
  // ------------------------------------------------------------
  localparam logic [3:0] OFS_WINDOW    = 4'h0;
  localparam logic [3:0] OFS_COUNT     = 4'h1;
  localparam logic [3:0] OFS_CTRL      = 4'h2;
  localparam logic [3:0] OFS_STATUS    = 4'h3;
  localparam logic [3:0] OFS_CMP_A     = 4'h4;
  localparam logic [3:0] OFS_CMP_B     = 4'h5;
  localparam logic [3:0] OFS_DATA_A    = 4'h6;
  localparam logic [3:0] OFS_DMASK_A   = 4'h7;

  // ------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------
  localparam int CTRL_ARM_BIT     = 0;
  localparam int CTRL_SOFTWARE_TRIGGER_BIT_BIT    = 1;
  localparam int CTRL_TSRC_BIT    = 2;
  localparam int CTRL_BRK_EN_BIT  = 3;
  localparam int CTRL_BRK_SWI_BIT = 4;
  localparam int CTRL_ENDTRIG_BIT = 5;
  localparam int CTRL_MODE_LSB    = 6;
  localparam int CTRL_TAG_BIT     = 8;
  localparam int CTRL_RW_BIT      = 9;
  localparam int CTRL_RWEN_BIT    = 10;

  localparam int CNT_FULL_BIT     = 7;
  localparam int STAT_FULL_BIT    = 7;
  localparam int STAT_LOCK_BIT    = 1;
  localparam int STAT_ARMED_BIT   = 0;

  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int LINE_W      = 20;
  localparam int WIN_W       = 16;
  localparam int DEPTH       = 64;
  localparam int CNT_W       = 6;
  localparam int ADDR_W      = 16;

  typedef enum logic [1:0]
  {
    CMP_SIMPLE  = 2'b00,
    CMP_INSIDE  = 2'b01,
    CMP_OUTSIDE = 2'b11
  } dtb_cmp_mode_t;

  typedef enum logic [1:0]
  {
    SEQ_IDLE  = 2'b00,
    SEQ_ARMED = 2'b01,
    SEQ_FINAL = 2'b11
  } dtb_seq_t;

  // Monitored core bus cycle
  typedef struct packed
  {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       data;
    logic              fetch;
    logic              tag_exec;
    logic              boundary;
  } dtb_cpu_bus_t;

  // Breakpoint request to the core
  typedef struct packed
  {
    logic bgnd;
    logic software_interrupt;
  } dtb_brk_t;

endpackage : dtb_pkg

/* tb/dtb_trace_sva.sv */
`timescale 1ns/1ns
module dtb_trace_sva
  import dtb_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        resetn,
  // Register bus
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Breakpoint
  input wire dtb_brk_t    brk
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic      full_seen_r;
  wire       rd_ack = avs_read && !avs_waitrequest;
  wire [3:0] idx    = avs_address[5:2];
  sequence req_start; $rose(avs_read || avs_write); endsequence
  sequence one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
  // Full flag seen since last control write
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      full_seen_r <= 1'h0;
    else if (avs_write && !avs_waitrequest && idx == OFS_CTRL)
      full_seen_r <= 1'h0;
    else if (rd_ack && idx == OFS_COUNT && avs_readdata[CNT_FULL_BIT])
      full_seen_r <= 1'h1;
  wait_state_a: assert property (req_start |-> one_wait) else $error("no single wait");
  idle_nowait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest) else $error("idle wait");
  brk_excl_a: assert property (!(brk.bgnd && brk.software_interrupt)) else $error("both breaks");
  bgnd_pulse_a: assert property (brk.bgnd |=> !brk.bgnd) else $error("bgnd too long");
  swi_pulse_a: assert property ($rose(brk.software_interrupt) |=> $fell(brk.software_interrupt)) else $error("swi too long");
  win_bad_a: assert property (rd_ack && idx == OFS_WINDOW &&
    (avs_byteenable[1:0] != 2'h3 || avs_address[1:0] != 2'h0) |-> avs_readdata == 32'h0) else $error("bad read");
  cnt_field_a: assert property (rd_ack && idx == OFS_COUNT |->
    avs_readdata[31:8] == 24'h0 && !avs_readdata[6]) else $error("count spare bits");
  full_kept_a: assert property (rd_ack && idx == OFS_COUNT && full_seen_r |-> avs_readdata[7]) else $error("full lost");
  stat_full_a: assert property (rd_ack && idx == OFS_STATUS && full_seen_r |-> avs_readdata[7]) else $error("status full");
endmodule : dtb_trace_sva
bind dtb_trace dtb_trace_sva u_sva (.sys_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .brk);

/* tb/dtb_core_model.sv */
`timescale 1ns/1ns
module dtb_core_model
  import dtb_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // Stimulus
  input  wire logic              slow,
  input  wire logic              wr,
  input  wire logic [ADDR_W-1:0] addr,
  // Core bus
  output dtb_cpu_bus_t           cpu_bus
);
  logic [1:0] ph_r;
  logic       v;
  assign v = !slow || ph_r == 2'h2;
  // Slow pace: one bus cycle in three; idle lines toggle
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ph_r    <= 2'h0;
      cpu_bus <= '0;
    end
    else
    begin
      ph_r             <= v ? 2'h0 : ph_r + 2'h1;
      cpu_bus.valid    <= v;
      cpu_bus.write    <= wr && v;
      cpu_bus.addr     <= v ? addr : ~cpu_bus.addr;
      cpu_bus.data     <= ~cpu_bus.data;
      cpu_bus.fetch    <= v;
      cpu_bus.tag_exec <= 1'h0;
      cpu_bus.boundary <= v;
    end
  end
endmodule : dtb_core_model

/* tb/tb_debug_trace_buffer_readout.sv */
`timescale 1ns/1ns
module tb_debug_trace_buffer_readout
  import dtb_pkg::*;
;
  localparam logic [5:0] A_WIN = {OFS_WINDOW, 2'h0};
  localparam logic [5:0] A_CNT = {OFS_COUNT, 2'h0};
  localparam logic [5:0] A_CTL = {OFS_CTRL, 2'h0};
  localparam logic [5:0] A_STS = {OFS_STATUS, 2'h0};
  logic         sys_clk, resetn, sys_resetn, avs_read, avs_write, avs_waitrequest, slow, wr, secured;
  logic [5:0]   avs_address;
  logic [3:0]   avs_byteenable;
  logic [31:0]  avs_writedata, avs_readdata;
  logic [15:0]  addr;
  dtb_cpu_bus_t cpu_bus;
  dtb_brk_t     brk;
  logic [63:0]  exp_q[$];
  logic [1:0]   brk_q[$];
  logic [63:0]  e;
  int           mismatches, num_checks, cyc, seed;
  dtb_trace dut (.sys_clk, .resetn, .sys_resetn, .avs_address, .avs_read, .avs_write, .avs_byteenable,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .cpu_bus, .secured, .brk);
  dtb_core_model core (.sys_clk, .resetn, .slow, .wr, .addr, .cpu_bus);
  initial
  begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end
  // ------
  // Bus tasks
  // ------
  task automatic bus(input logic w, input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
    avs_address    <= a;
    avs_byteenable <= be;
    avs_writedata  <= d;
    avs_read       <= !w;
    avs_write      <= w;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'h0)
      @(posedge sys_clk);
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
    @(posedge sys_clk);
  endtask : bus
  task automatic rd(input logic [5:0] a, input logic [31:0] v, input logic [31:0] m = '1, input logic [3:0] be = 4'hf);
    exp_q.push_back({m, v});
    bus(1'h0, a, be, 32'h0);
  endtask : rd
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    bus(1'h1, a, 4'hf, d);
  endtask : wr_reg
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask : check
  task automatic conclude;
    mismatches += exp_q.size() + brk_q.size();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  // ------
  // Monitor and timeout
  // ------
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      mismatches++;
      conclude();
    end
    if (resetn && avs_read && !avs_waitrequest)
    begin
      e = exp_q.size() ? exp_q.pop_front() : 64'h0;
      check("readdata", avs_readdata & e[63:32], e[31:0]);
    end
    if (brk !== 2'h0)
      check("brk", brk, brk_q.size() ? brk_q.pop_front() : 2'h0);
  end
  initial
  begin
    {resetn, sys_resetn, avs_read, avs_write, secured, wr} = '0;
    {avs_address, avs_byteenable, avs_writedata, cyc, mismatches, num_checks} = '0;
    {slow, wr, addr, seed} = {2'h1, 16'h0, 32'd14};
    repeat (20) @(posedge sys_clk);
    resetn     <= 1'h1;
    sys_resetn <= 1'h1;
    @(posedge sys_clk);
    rd(A_CNT, 32'h0);
    wr_reg(A_CNT, $random(seed));
    rd(A_CNT, 32'h0);
    wr_reg(6'h20, $random(seed));
    rd(6'h20, 32'h0);
    rd(A_WIN, 32'h0);
    addr <= $random(seed);
    secured <= 1'h1;
    wr_reg(A_CTL, 32'h7);
    repeat (10) @(posedge sys_clk);
    rd(A_CNT, 32'h0);
    secured <= 1'h0;
    wr_reg(A_CTL, 32'h7);
    repeat (10) @(posedge sys_clk);
    rd(A_CNT, 32'h1);
    wr_reg(A_CTL, 32'h0);
    wr_reg(A_WIN, 32'h0);
    rd(A_WIN, 32'h0);
    wr_reg(A_CTL, 32'h4);
    rd(A_WIN, 32'h0, '1, 4'h1);
    rd(6'h02, 32'h0, '1, 4'h3);
    rd(A_WIN, {16'h0, addr});
    rd(A_WIN, 32'h8);
    rd(A_CNT, 32'h1);
    sys_resetn <= 1'h0;
    repeat (3) @(posedge sys_clk);
    sys_resetn <= 1'h1;
    rd(A_CNT, 32'h1);
    brk_q.push_back(2'h2);
    wr_reg(A_CTL, 32'hb);
    repeat (5) @(posedge sys_clk);
    brk_q.push_back(2'h1);
    wr_reg(A_CTL, 32'h1b);
    repeat (5) @(posedge sys_clk);
    wr_reg({OFS_CMP_A, 2'h0}, 32'h0);
    wr_reg({OFS_CMP_B, 2'h0}, 32'hffff);
    brk_q.push_back(2'h2);
    wr_reg(A_CTL, 32'h4d);
    repeat (8) @(posedge sys_clk);
    wr_reg(A_CTL, 32'hcd);
    repeat (8) @(posedge sys_clk);
    slow <= 1'h0;
    wr_reg(A_CTL, 32'h27);
    repeat (80) @(posedge sys_clk);
    rd(A_CNT, 32'h80, 32'h80);
    rd(A_STS, 32'h80, 32'h80);
    wr_reg(A_CTL, 32'h1);
    rd(A_CNT, 32'h0, 32'h80);
    resetn <= 1'h0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'h1;
    @(posedge sys_clk);
    rd(A_CNT, 32'h0);
    conclude();
  end
endmodule : tb_debug_trace_buffer_readout
